// ### pkg/stsq_params.svh
`ifndef STSQ_PARAMS_SVH
`define STSQ_PARAMS_SVH

// Register byte offsets
`define STSQ_CTRL_ADDR    8'h00
`define STSQ_EDGE_ADDR    8'h04
`define STSQ_SEQ_ADDR     8'h08
`define STSQ_FINAL_ADDR   8'h0c
`define STSQ_RESTART_ADDR 8'h10
`define STSQ_OCC_ADDR     8'h14
`define STSQ_STATUS_ADDR  8'h18
`define STSQ_LABEL_BASE   8'h40
`define STSQ_TLBL_BASE    8'h60
`define STSQ_TVAL_BASE    8'h80

// CTRL fields
`define STSQ_CTRL_TMODE    0
`define STSQ_CTRL_SMODE_LO 1
`define STSQ_CTRL_SMODE_HI 2
`define STSQ_CTRL_TWOPH    3
`define STSQ_CTRL_REARM    4
`define STSQ_CTRL_FAND     5

// Resource codes
`define STSQ_RES_ANY  4'h8
`define STSQ_RES_NONE 4'h9

// Reset values and occurrence limit
`define STSQ_EDGE_RST 15'h7015
`define STSQ_OCC_RST  16'h0001
`define STSQ_OCC_MAX  16'hea5f

`endif

// ### pkg/stsq_pkg.sv
package stsq_pkg;

   typedef enum logic {
      STSQ_TRIG_STATE_ONLY = 1'b0,
      STSQ_TRIG_ARM_ANALOG = 1'b1
   } stsq_tmode_e;

   typedef enum logic [1:0] {
      STSQ_SM_NORMAL    = 2'b00,
      STSQ_SM_QUALIFIED = 2'b01,
      STSQ_SM_MISSING   = 2'b10,
      STSQ_SM_EXTRA     = 2'b11
   } stsq_smode_e;

   typedef enum logic [1:0] {
      STSQ_ST_SEARCH = 2'b00,
      STSQ_ST_ARMED  = 2'b01,
      STSQ_ST_DONE   = 2'b10
   } stsq_state_e;

   typedef struct packed {
      stsq_tmode_e tmode;
      stsq_smode_e smode;
      logic        two_phase;
      logic        final_and;
   } stsq_ctrl_s;

   typedef struct packed {
      logic [3:0][3:0] sel;
      logic [3:0]      en;
   } stsq_resset_s;

endpackage : stsq_pkg

// ### core/stsq_sequencer.sv
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`include "stsq_params.svh"

module stsq_sequencer #(
   parameter int PROBES = 27,
   parameter int NCLK   = 3
) (
   // System
   input  wire logic              CLK,
   input  wire logic              NRST,
   // Wishbone slave
   input  wire logic              WB_CYC_I,
   input  wire logic              WB_STB_I,
   input  wire logic              WB_WE_I,
   input  wire logic [7:0]        WB_ADR_I,
   input  wire logic [3:0]        WB_SEL_I,
   input  wire logic [31:0]       WB_DAT_I,
   output logic      [31:0]       WB_DAT_O,
   output logic                   WB_ACK_O,
   // Probed system
   input  wire logic [PROBES-1:0] PROBE_DATA,
   input  wire logic [NCLK-1:0]   PROBE_CLK,
   input  wire logic              ANALOG_TRIG,
   // Results
   output logic                   ACQ_TRIG,
   output logic                   ANALOG_ARMED
);

   // Probe sync stages
   logic [PROBES-1:0] data_s1_ff, data_s2_ff;
   logic [NCLK-1:0]   clk_s1_ff, clk_s2_ff, clk_s3_ff;
   logic              ana_s1_ff, ana_s2_ff, ana_s3_ff;

   // Configuration
   stsq_pkg::stsq_ctrl_s   ctrl_ff;
   logic [14:0]            edge_ff;
   logic [1:0]             nsteps_ff;
   logic [3:0][3:0]        step_sel_ff;
   stsq_pkg::stsq_resset_s final_ff, restart_ff;
   logic [15:0]            occ_ff;
   logic [PROBES-1:0]      label_mask_ff [8];
   logic [7:0]             term_lbl_ff [4];
   logic [PROBES-1:0]      term_val_ff [4];

   // Sequencer state
   stsq_pkg::stsq_state_e state_ff;
   logic [1:0]            step_ff;
   logic [15:0]           count_ff;
   logic                  qual_seen_ff;
   logic                  phase_ff;
   logic                  rearm;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // Edge detect per clock with a 2-bit select: 01 rising, 10 falling, 11 both
   function automatic logic edge_hit(input logic cur, input logic prev, input logic [1:0] sel);
      return (sel[0] & cur & ~prev) | (sel[1] & ~cur & prev);
   endfunction : edge_hit

   function automatic logic res_eval(input logic [3:0] code, input logic [3:0] terms);
      logic r;
      r = 1'b0;
      if (code < 4'h4) begin
         r = terms[code[1:0]];
      end else if (code < 4'h8) begin
         r = ~terms[code[1:0]];
      end else if (code == `STSQ_RES_ANY) begin
         r = 1'b1;
      end
      return r;
   endfunction : res_eval

   // Input synchronisers
   always_ff @(posedge CLK) begin
      data_s1_ff <= PROBE_DATA;
      data_s2_ff <= data_s1_ff;
      clk_s1_ff  <= PROBE_CLK;
      clk_s2_ff  <= clk_s1_ff;
      clk_s3_ff  <= clk_s2_ff;
      ana_s1_ff  <= ANALOG_TRIG;
      ana_s2_ff  <= ana_s1_ff;
      ana_s3_ff  <= ana_s2_ff;
   end

   // Wishbone access
   logic        wb_req;
   logic        wb_wr;
   logic [31:0] rd_data;

   assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   assign wb_wr  = wb_req & WB_WE_I;
   assign rearm  = wb_wr & (WB_ADR_I == `STSQ_CTRL_ADDR) & WB_SEL_I[0] & WB_DAT_I[`STSQ_CTRL_REARM];

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
      end else begin
         WB_ACK_O <= wb_req;
         WB_DAT_O <= wb_req ? rd_data : 32'h0000_0000;
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      case (WB_ADR_I)
         `STSQ_CTRL_ADDR:    rd_data = {26'h0, ctrl_ff.final_and, 1'b0, ctrl_ff.two_phase, ctrl_ff.smode,
                                        ctrl_ff.tmode};
         `STSQ_EDGE_ADDR:    rd_data = {17'h0, edge_ff};
         `STSQ_SEQ_ADDR:     rd_data = {14'h0, step_sel_ff, nsteps_ff};
         `STSQ_FINAL_ADDR:   rd_data = {12'h0, final_ff.en, final_ff.sel};
         `STSQ_RESTART_ADDR: rd_data = {12'h0, restart_ff.en, restart_ff.sel};
         `STSQ_OCC_ADDR:     rd_data = {16'h0, occ_ff};
         `STSQ_STATUS_ADDR:  rd_data = {count_ff, 10'h0, qual_seen_ff, phase_ff, step_ff, state_ff};
         default: begin
            if (WB_ADR_I[7:5] == 3'h2) begin
               rd_data = {5'h0, label_mask_ff[WB_ADR_I[4:2]]};
            end else if (WB_ADR_I[7:4] == 4'h6) begin
               rd_data = {24'h0, term_lbl_ff[WB_ADR_I[3:2]]};
            end else if (WB_ADR_I[7:4] == 4'h8) begin
               rd_data = {5'h0, term_val_ff[WB_ADR_I[3:2]]};
            end
         end
      endcase
   end

   // Register writes
   always_ff @(posedge CLK) begin
      logic [31:0] w;
      if (!NRST) begin
         ctrl_ff     <= '{tmode: stsq_pkg::STSQ_TRIG_STATE_ONLY, smode: stsq_pkg::STSQ_SM_NORMAL,
                          two_phase: 1'b0, final_and: 1'b0};
         edge_ff     <= `STSQ_EDGE_RST;
         nsteps_ff   <= 2'h0;
         step_sel_ff <= '0;
         final_ff    <= '0;
         restart_ff  <= '0;
         occ_ff      <= `STSQ_OCC_RST;
         for (int i = 0; i < 8; i++) begin
            label_mask_ff[i] <= '0;
         end
         for (int i = 0; i < 4; i++) begin
            term_lbl_ff[i] <= 8'h00;
            term_val_ff[i] <= '0;
         end
      end else if (wb_wr) begin
         case (WB_ADR_I)
            `STSQ_CTRL_ADDR: begin
               w = merge({26'h0, ctrl_ff.final_and, 1'b0, ctrl_ff.two_phase, ctrl_ff.smode, ctrl_ff.tmode},
                         WB_DAT_I, WB_SEL_I);
               ctrl_ff.tmode     <= stsq_pkg::stsq_tmode_e'(w[`STSQ_CTRL_TMODE]);
               ctrl_ff.smode     <= stsq_pkg::stsq_smode_e'(w[`STSQ_CTRL_SMODE_HI:`STSQ_CTRL_SMODE_LO]);
               ctrl_ff.two_phase <= w[`STSQ_CTRL_TWOPH];
               ctrl_ff.final_and <= w[`STSQ_CTRL_FAND];
            end
            `STSQ_EDGE_ADDR: begin
               w = merge({17'h0, edge_ff}, WB_DAT_I, WB_SEL_I);
               edge_ff <= w[14:0];
            end
            `STSQ_SEQ_ADDR: begin
               w = merge({14'h0, step_sel_ff, nsteps_ff}, WB_DAT_I, WB_SEL_I);
               nsteps_ff   <= w[1:0];
               step_sel_ff <= w[17:2];
            end
            `STSQ_FINAL_ADDR: begin
               w = merge({12'h0, final_ff.en, final_ff.sel}, WB_DAT_I, WB_SEL_I);
               final_ff <= '{sel: w[15:0], en: w[19:16]};
            end
            `STSQ_RESTART_ADDR: begin
               w = merge({12'h0, restart_ff.en, restart_ff.sel}, WB_DAT_I, WB_SEL_I);
               restart_ff <= '{sel: w[15:0], en: w[19:16]};
            end
            `STSQ_OCC_ADDR: begin
               w = merge({16'h0, occ_ff}, WB_DAT_I, WB_SEL_I);
               // Clamp to the largest count; zero acts as one
               occ_ff <= (w[15:0] > `STSQ_OCC_MAX) ? `STSQ_OCC_MAX : w[15:0];
            end
            default: begin
               if (WB_ADR_I[7:5] == 3'h2) begin
                  w = merge({5'h0, label_mask_ff[WB_ADR_I[4:2]]}, WB_DAT_I, WB_SEL_I);
                  label_mask_ff[WB_ADR_I[4:2]] <= w[PROBES-1:0];
               end else if (WB_ADR_I[7:4] == 4'h6) begin
                  w = merge({24'h0, term_lbl_ff[WB_ADR_I[3:2]]}, WB_DAT_I, WB_SEL_I);
                  term_lbl_ff[WB_ADR_I[3:2]] <= w[7:0];
               end else if (WB_ADR_I[7:4] == 4'h8) begin
                  w = merge({5'h0, term_val_ff[WB_ADR_I[3:2]]}, WB_DAT_I, WB_SEL_I);
                  term_val_ff[WB_ADR_I[3:2]] <= w[PROBES-1:0];
               end
            end
         endcase
      end
   end

   // Combined sampling edge; polarity is applied per clock before the OR
   logic [NCLK-1:0] clk_hit;
   logic            samp;
   logic            qual_edge;

   always_comb begin
      for (int i = 0; i < NCLK; i++) begin
         clk_hit[i] = edge_ff[12+i] &
                      edge_hit(clk_s2_ff[i], clk_s3_ff[i],
                               (ctrl_ff.two_phase && phase_ff) ? edge_ff[6+2*i +: 2] : edge_ff[2*i +: 2]);
      end
   end

   assign samp = |clk_hit;
   // Slave clock is the last target clock
   assign qual_edge = edge_hit(clk_s2_ff[NCLK-1], clk_s3_ff[NCLK-1], edge_ff[2*(NCLK-1) +: 2]);

   // Two-phase demux: edges alternate between phase selections
   always_ff @(posedge CLK) begin
      if (!NRST || rearm) begin
         phase_ff <= 1'b0;
      end else if (samp && ctrl_ff.two_phase) begin
         phase_ff <= ~phase_ff;
      end
   end

   // Term match: AND over all enabled labels of that term
   logic [3:0]        term_hit;
   logic [PROBES-1:0] care;

   always_comb begin
      for (int t = 0; t < 4; t++) begin
         care = '0;
         for (int l = 0; l < 8; l++) begin
            if (term_lbl_ff[t][l]) begin
               care = care | label_mask_ff[l];
            end
         end
         term_hit[t] = ((data_s2_ff ^ term_val_ff[t]) & care) == '0;
      end
   end

   // Step, final and restart conditions
   logic step_hit;
   logic final_hit;
   logic restart_hit;
   logic [3:0] fin_v;

   always_comb begin
      step_hit = res_eval(step_sel_ff[step_ff], term_hit);
      restart_hit = 1'b0;
      for (int i = 0; i < 4; i++) begin
         fin_v[i] = res_eval(final_ff.sel[i], term_hit);
         restart_hit = restart_hit | (restart_ff.en[i] & res_eval(restart_ff.sel[i], term_hit));
      end
      if (ctrl_ff.final_and) begin
         final_hit = (final_ff.en != 4'h0) && ((fin_v | ~final_ff.en) == 4'hf);
      end else begin
         final_hit = |(fin_v & final_ff.en);
      end
      // Serial modes force the last step: missing bit is term a absent, extra bit is term a present
      case (ctrl_ff.smode)
         stsq_pkg::STSQ_SM_MISSING: final_hit = ~term_hit[0];
         stsq_pkg::STSQ_SM_EXTRA:   final_hit = term_hit[0];
         default:                   final_hit = final_hit;
      endcase
   end

   // Qualify clock latch
   always_ff @(posedge CLK) begin
      if (!NRST || rearm) begin
         qual_seen_ff <= 1'b0;
      end else if (qual_edge) begin
         qual_seen_ff <= 1'b1;
      end
   end

   logic active;
   logic cnt_done;

   assign active   = samp && (state_ff == stsq_pkg::STSQ_ST_SEARCH) &&
                     (ctrl_ff.smode != stsq_pkg::STSQ_SM_QUALIFIED || qual_seen_ff);
   assign cnt_done = (count_ff + 16'h0001) >= occ_ff;

   // Sequence stepping
   always_ff @(posedge CLK) begin
      if (!NRST || rearm) begin
         step_ff  <= 2'h0;
         count_ff <= 16'h0000;
      end else if (active) begin
         if (restart_hit) begin
            step_ff  <= 2'h0;
            count_ff <= 16'h0000;
         end else if (step_ff != nsteps_ff) begin
            if (step_hit) begin
               step_ff <= step_ff + 2'h1;
            end
         end else if (final_hit && !cnt_done) begin
            count_ff <= count_ff + 16'h0001;
         end
      end
   end

   // Trigger outcome
   logic seq_done;
   logic ana_edge;

   assign seq_done = active && !restart_hit && (step_ff == nsteps_ff) && final_hit && cnt_done;
   assign ana_edge = ana_s2_ff & ~ana_s3_ff;

   always_ff @(posedge CLK) begin
      if (!NRST || rearm) begin
         state_ff <= stsq_pkg::STSQ_ST_SEARCH;
         ACQ_TRIG <= 1'b0;
      end else begin
         ACQ_TRIG <= 1'b0;
         case (state_ff)
            stsq_pkg::STSQ_ST_SEARCH: begin
               if (seq_done) begin
                  if (ctrl_ff.tmode == stsq_pkg::STSQ_TRIG_ARM_ANALOG) begin
                     state_ff <= stsq_pkg::STSQ_ST_ARMED;
                  end else begin
                     state_ff <= stsq_pkg::STSQ_ST_DONE;
                     ACQ_TRIG <= 1'b1;
                  end
               end
            end
            stsq_pkg::STSQ_ST_ARMED: begin
               if (ana_edge) begin
                  state_ff <= stsq_pkg::STSQ_ST_DONE;
                  ACQ_TRIG <= 1'b1;
               end
            end
            stsq_pkg::STSQ_ST_DONE: state_ff <= stsq_pkg::STSQ_ST_DONE;
            default:                state_ff <= stsq_pkg::STSQ_ST_SEARCH;
         endcase
      end
   end

   assign ANALOG_ARMED = (state_ff == stsq_pkg::STSQ_ST_ARMED);

endmodule : stsq_sequencer

// ### verification/stsq_sequencer_assertions.sv
`timescale 1ns/10ps
module stsq_sequencer_assertions #(
   parameter int NCLK = 3
) (
   // System
   input wire logic            CLK,
   input wire logic            NRST,
   // Bus
   input wire logic            WB_CYC_I,
   input wire logic            WB_STB_I,
   input wire logic [31:0]     WB_DAT_O,
   input wire logic            WB_ACK_O,
   // Probe side
   input wire logic [NCLK-1:0] PROBE_CLK,
   input wire logic            ANALOG_TRIG,
   input wire logic            ACQ_TRIG,
   input wire logic            ANALOG_ARMED
);
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (!NRST);

   bus_ack_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("no ack");
   ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack too long");
   ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
      else $error("ack without request");
   dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == '0)
      else $error("read data outside ack");
   trig_pulse_a: assert property (ACQ_TRIG |=> !ACQ_TRIG)
      else $error("trigger too long");
   analog_fire_a: assert property (ANALOG_ARMED && $rose(ANALOG_TRIG) |-> ##[1:6] ACQ_TRIG)
      else $error("analog edge lost");
   armed_drop_a: assert property ($fell(ANALOG_ARMED) |-> ##[0:1] (ACQ_TRIG || $past(ACQ_TRIG)
      || WB_ACK_O || $past(WB_ACK_O)))
      else $error("arm lost");
   start_quiet_a: assert property ($rose(NRST) |-> !ACQ_TRIG [*3])
      else $error("trigger after reset");
   trig_cause_a: assert property (ACQ_TRIG && !$past(ANALOG_ARMED)
      |-> $past(PROBE_CLK, 2) != $past(PROBE_CLK, 7))
      else $error("trigger without clock edge");

   trig_c: cover property (ACQ_TRIG);
   armed_c: cover property ($rose(ANALOG_ARMED));
   ack_c: cover property (WB_ACK_O);
endmodule : stsq_sequencer_assertions

// ### verification/stsq_probe_model.sv
`timescale 1ns/10ps
module stsq_probe_model (
   // Probe pins
   output logic [26:0] data,
   output logic [2:0]  pclk
);
   initial begin
      data = '0;
      pclk = '0;
   end
   // Clocks stand still between frames; released data is inverted
   task automatic emit(input logic [26:0] d, input logic [2:0] m);
      data = d;
      #20 pclk = pclk ^ m;
      #62.5 pclk = pclk ^ m;
      #20 data = ~d;
      #22.5;
   endtask : emit
endmodule : stsq_probe_model

// ### verification/stsq_sequencer_tb_top.sv
`timescale 1ns/10ps
`include "stsq_params.svh"
module stsq_sequencer_tb_top;
   localparam logic [31:0] er = `STSQ_EDGE_RST;
   localparam logic [31:0] fa = 32'h10000;
   localparam logic [26:0] da = 27'h4000005;
   localparam logic [26:0] db = 27'h7000000;
   logic        clk, nrst, cyc, stb, we, ack, acq, armed, atrig;
   logic [7:0]  adr;
   logic [31:0] dat_i, dat_o, q;
   logic [26:0] pdata;
   logic [2:0]  pclk;
   int          fails = 0, n_compared = 0, ntrig = 0;

   stsq_sequencer dut (
      .CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(4'hf), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .PROBE_DATA(pdata),
      .PROBE_CLK(pclk), .ANALOG_TRIG(atrig), .ACQ_TRIG(acq), .ANALOG_ARMED(armed)
   );
   stsq_probe_model pm (.data(pdata), .pclk(pclk));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      if (acq === 1'b1) ntrig++;
   end

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
      n_compared++;
      if (v !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", s, e, v);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      {cyc, stb, we, adr, dat_i} <= {2'b11, w, a, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = dat_o;
      if (n >= 50) begin
         fails++;
         $display("[ERR] ack exp 1 got %b", ack);
      end
      {cyc, stb} <= 2'b00;
      @(posedge clk);
   endtask : bus

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, '0);
      chk("reg", e, q);
   endtask : rdc

   // Rearm with every setup so count, phase and qualify start clean
   task automatic cfg(input logic [31:0] c, e, s, f, r, o);
      bus(1'b1, 8'h04, e);
      bus(1'b1, 8'h08, s);
      bus(1'b1, 8'h0c, f);
      bus(1'b1, 8'h10, r);
      bus(1'b1, 8'h14, o);
      bus(1'b1, 8'h00, c | 32'h10);
   endtask : cfg

   task automatic go(input logic [26:0] d, input logic [2:0] m, input int e);
      int t;
      t = ntrig;
      pm.emit(d, m);
      repeat (8) @(posedge clk);
      chk("trig", e, ntrig - t);
   endtask : go

   task automatic t_regs;
      rdc(8'h00, '0);
      rdc(8'h04, er);
      rdc(8'h3c, '0);
      bus(1'b1, 8'h14, 32'hffff);
      rdc(8'h14, `STSQ_OCC_MAX);
      bus(1'b1, 8'h40, 32'hf);
      bus(1'b1, 8'h44, db);
      bus(1'b1, 8'h60, 32'h1);
      bus(1'b1, 8'h64, 32'h2);
      bus(1'b1, 8'h80, 32'h5);
      bus(1'b1, 8'h84, db);
      bus(1'b1, 8'h68, 32'h3);
      bus(1'b1, 8'h88, 32'h7000005);
      rdc(8'h84, db);
   endtask : t_regs

   task automatic t_seq;
      cfg(0, er, 0, fa, 32'h10004, 3);
      go(da, 1, 0);
      go(da, 1, 0);
      go(0, 1, 0);
      go(da, 1, 0);
      go(da, 1, 0);
      go(da, 1, 1);
      go(da, 1, 0);
      cfg(0, er, 32'h5, fa, 0, 1);
      go(da, 1, 0);
      go(db, 1, 0);
      go(da, 1, 1);
   endtask : t_seq

   task automatic t_res;
      logic [31:0] f[9] = '{32'h10004, 32'h10008, 32'h10009, 32'h30010, 32'h30010, 32'h30010, 32'h10005,
                            32'h10002, 32'h10002};
      logic [31:0] c[9] = '{0, 0, 0, 0, 32'h20, 32'h20, 0, 0, 0};
      logic [26:0] d[9] = '{da, 27'h6, da, db, db, 27'h7000005, da, 27'h7000005, da};
      int          x[9] = '{0, 1, 0, 1, 0, 1, 1, 1, 0};
      for (int i = 0; i < 9; i++) begin
         cfg(c[i], er, 0, f[i], 0, 1);
         go(d[i], 1, x[i]);
      end
   endtask : t_res

   task automatic t_edge;
      logic [31:0] e[6] = '{32'h1001, 32'h1003, 32'h300c, 32'h300c, 32'h1081, 32'h1001};
      logic [2:0]  m[6] = '{1, 1, 1, 2, 1, 1};
      int          x[6] = '{0, 1, 0, 1, 1, 0};
      for (int i = 0; i < 6; i++) begin
         cfg(i > 3 ? 8 : 0, e[i], 0, fa, 0, 2);
         go(da, m[i], x[i]);
      end
   endtask : t_edge

   task automatic t_mode;
      int t;
      cfg(2, er, 0, fa, 0, 1);
      go(da, 1, 0);
      go(0, 4, 0);
      go(da, 1, 1);
      cfg(4, er, 0, fa, 0, 1);
      go(da, 1, 0);
      go(0, 1, 1);
      cfg(6, er, 0, fa, 0, 1);
      go(0, 1, 0);
      go(da, 1, 1);
      cfg(1, er, 0, fa, 0, 1);
      go(da, 1, 0);
      chk("armed", 1, armed);
      rdc(8'h18, 32'h1);
      t = ntrig;
      atrig <= 1'b1;
      repeat (8) @(posedge clk);
      atrig <= 1'b0;
      chk("trig", 1, ntrig - t);
      chk("armed", 0, armed);
   endtask : t_mode

   task automatic summarize;
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   initial begin
      {nrst, cyc, stb, we, atrig, adr, dat_i} = '0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_regs();
      t_seq();
      t_res();
      t_edge();
      t_mode();
      summarize();
   end
   initial begin
      #100000;
      fails++;
      $display("[ERR] run exp done got timeout");
      summarize();
   end
endmodule : stsq_sequencer_tb_top

bind stsq_sequencer stsq_sequencer_assertions #(.NCLK(NCLK)) u_chk (
   .CLK(CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .PROBE_CLK(PROBE_CLK), .ANALOG_TRIG(ANALOG_TRIG), .ACQ_TRIG(ACQ_TRIG),
   .ANALOG_ARMED(ANALOG_ARMED)
);
